// *** design/msc_pkg.sv ***
// Package: register map, field layout and timing constants for the sample configuration block
package msc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RATE_DIV   = 8'h19;
  localparam logic [7:0] ADDR_SYNC_FILT  = 8'h1A;
  localparam logic [7:0] ADDR_GYRO_CFG   = 8'h1B;
  localparam logic [7:0] ADDR_ACCEL_CFG  = 8'h1C;

  // Reset values
  localparam logic [7:0] RESET_VALUE     = 8'h00;

  // Writable-bit masks (reserved bits read zero)
  localparam logic [7:0] MASK_RATE_DIV   = 8'hFF;
  localparam logic [7:0] MASK_SYNC_FILT  = 8'h3F;
  localparam logic [7:0] MASK_GYRO_CFG   = 8'hF8;
  localparam logic [7:0] MASK_ACCEL_CFG  = 8'hF8;

  // Field positions
  localparam int SYNC_LSB    = 3;
  localparam int FILT_LSB    = 0;
  localparam int RANGE_LSB   = 3;
  localparam int ST_X_BIT    = 7;
  localparam int ST_Y_BIT    = 6;
  localparam int ST_Z_BIT    = 5;

  // Filter settings that bypass the low-pass filter
  localparam logic [2:0] FILT_OFF_LO   = 3'h0;
  localparam logic [2:0] FILT_OFF_HI   = 3'h7;

  // Sync location codes
  localparam logic [2:0] SYNC_DISABLED = 3'h0;

  // Timing: clock and output rates
  localparam int CLOCK_HZ       = 100_000_000;
  localparam int GYRO_FAST_HZ   = 8_000;
  localparam int GYRO_SLOW_HZ   = 1_000;
  localparam int ACCEL_HZ       = 1_000;
  localparam int FAST_CYCLES    = CLOCK_HZ / GYRO_FAST_HZ;
  localparam int SLOW_CYCLES    = CLOCK_HZ / GYRO_SLOW_HZ;
  localparam int ACCEL_CYCLES   = CLOCK_HZ / ACCEL_HZ;
  localparam int TICK_W         = 17;

  // Decoded configuration that leaves the block
  typedef struct packed {
    logic [2:0] gyro_selftest;   // X,Y,Z
    logic [2:0] accel_selftest;  // X,Y,Z
    logic [1:0] gyro_range_code;
    logic [1:0] accel_range_code;
    logic [2:0] lowpass_setting;
  } msc_cfg_s;

  // Per-sample output strobes
  typedef struct packed {
    logic       sample_tick;
    logic       accel_new;
    logic       sync_value;
    logic [7:0] sync_onehot;     // bit n: location code n, n 1..7; code 0 sets no bit
  } msc_smp_s;

endpackage : msc_pkg

// *** design/msc_top.sv ***
// Top: sample-rate divider, frame-sync latch and front-end configuration registers
//
// Functional notes
// [RULE_01] Sample rate equals gyro output rate divided by one plus divider value.
// [RULE_02] Gyro rate is 8 kHz for filter settings 0 and 7, else 1 kHz.
// [RULE_03] Accelerometer updates at 1 kHz; faster sampling repeats the same sample.
// [RULE_04] Output registers, FIFO, motion processor and detection all use the sample tick.
// [RULE_05] Divider is an 8-bit read/write register at 0x19.
// [RULE_06] Any frame-sync change is latched so short strobes are caught; the code holds only the first change after each sample.
// [RULE_07] Latch sampled once per sample; then reloaded with present pin level.
// [RULE_08] Sampled sync replaces bit 0 of the low byte chosen by the location field.
// [RULE_09] Register 0x1A: location bits 5..3, filter bits 2..0, bits 7..6 reserved.
// [RULE_10] Filter setting picks bandwidths 260 Hz down to 5 Hz; setting 7 reserved.
// [RULE_11] Gyro config bits 7,6,5 start X,Y,Z gyro self-test, singly or together.
// [RULE_12] Accel config bits 7,6,5 start X,Y,Z accelerometer self-test.
// [RULE_13] A set self-test bit actuates that axis so its output shifts.
// [RULE_14] Host computes response as enabled output minus disabled output.
// [RULE_15] Host passes the test when the response lies within limits.
// [RULE_16] Gyro range code at 0x1B bits 4..3 selects 250 to 2000 deg/s.
// [RULE_17] Gyro config bits 2..0 are reserved with no function.
// [RULE_18] Accel range code at 0x1C bits 4..3 selects 2 to 16 g.
// [RULE_19] All four registers reset to zero.
// [RULE_20] Reserved bits read zero and ignore writes.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module msc_top (
  input  wire logic                I_CLOCK,
  input  wire logic                I_RESET_N,
  input  wire logic [7:0]          i_ADDR,
  input  wire logic [7:0]          i_WDATA,
  input  wire logic                i_WRITE,
  input  wire logic                i_READ,
  input  wire logic                i_FRAME_SYNC_INPUT,
  output logic [7:0]               o_RDATA,
  output msc_pkg::msc_cfg_s        o_CFG,
  output msc_pkg::msc_smp_s        o_SMP
);

  // Registers
  logic [7:0] rate_divider_value;
  logic [7:0] sync_and_filter_config;
  logic [7:0] gyro_range_selftest;
  logic [7:0] accel_range_selftest;

  // Frame-sync synchroniser and latch
  logic       fs_meta;
  logic       fs_sync;
  logic       fs_prev;
  logic       fs_latch;
  logic       fs_caught;

  // Rate generation
  logic [msc_pkg::TICK_W-1:0] base_count;
  logic [7:0]                 div_count;
  logic [msc_pkg::TICK_W-1:0] accel_count;
  logic                       accel_fresh;

  // Masked write helper
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    masked = data & mask;
  endfunction : masked

  // Address decode
  wire        hit_div   = (i_ADDR == msc_pkg::ADDR_RATE_DIV);
  wire        hit_sf    = (i_ADDR == msc_pkg::ADDR_SYNC_FILT);
  wire        hit_gyro  = (i_ADDR == msc_pkg::ADDR_GYRO_CFG);
  wire        hit_accel = (i_ADDR == msc_pkg::ADDR_ACCEL_CFG);

  wire [2:0]  lowpass_setting      = sync_and_filter_config[msc_pkg::FILT_LSB +: 3];
  wire [2:0]  sync_location_select = sync_and_filter_config[msc_pkg::SYNC_LSB +: 3];

  // Filter bypass selects the fast gyro rate
  wire        gyro_fast = (lowpass_setting == msc_pkg::FILT_OFF_LO) ||
                          (lowpass_setting == msc_pkg::FILT_OFF_HI); // RULE_02
  wire [msc_pkg::TICK_W-1:0] base_period = gyro_fast ?
                          msc_pkg::TICK_W'(msc_pkg::FAST_CYCLES) :
                          msc_pkg::TICK_W'(msc_pkg::SLOW_CYCLES);    // RULE_02
  wire        base_tick   = (base_count >= base_period - msc_pkg::TICK_W'(1));
  wire        sample_tick = base_tick && (div_count >= rate_divider_value); // RULE_01
  wire        accel_tick  = (accel_count == msc_pkg::TICK_W'(msc_pkg::ACCEL_CYCLES - 1));

  wire [7:0]  read_mux = hit_div   ? rate_divider_value     :
                         hit_sf    ? sync_and_filter_config :
                         hit_gyro  ? gyro_range_selftest    :
                         hit_accel ? accel_range_selftest   : 8'h00;

  wire        fs_change   = (fs_sync != fs_prev);
  wire [7:0]  next_onehot = (sync_location_select == msc_pkg::SYNC_DISABLED) ? 8'h00 :
                            (8'h01 << sync_location_select); // RULE_08

  // Register file
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      rate_divider_value     <= msc_pkg::RESET_VALUE; // RULE_19
      sync_and_filter_config <= msc_pkg::RESET_VALUE; // RULE_19
      gyro_range_selftest    <= msc_pkg::RESET_VALUE; // RULE_19
      accel_range_selftest   <= msc_pkg::RESET_VALUE; // RULE_19
    end else if (i_WRITE) begin
      if (hit_div) begin
        rate_divider_value <= masked(i_WDATA, msc_pkg::MASK_RATE_DIV); // RULE_05
      end
      if (hit_sf) begin
        sync_and_filter_config <= masked(i_WDATA, msc_pkg::MASK_SYNC_FILT); // RULE_09
      end
      if (hit_gyro) begin
        gyro_range_selftest <= masked(i_WDATA, msc_pkg::MASK_GYRO_CFG); // RULE_17
      end
      if (hit_accel) begin
        accel_range_selftest <= masked(i_WDATA, msc_pkg::MASK_ACCEL_CFG); // RULE_20
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      o_RDATA <= 8'h00;
    end else begin
      o_RDATA <= i_READ ? read_mux : 8'h00; // RULE_20
    end
  end

  // Gyro base rate and divider
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      base_count <= '0;
      div_count  <= 8'h00;
    end else begin
      base_count <= base_tick ? '0 : base_count + msc_pkg::TICK_W'(1);
      if (sample_tick) begin
        div_count <= 8'h00; // RULE_01
      end else if (base_tick) begin
        div_count <= div_count + 8'h01;
      end
    end
  end

  // Accelerometer runs on its own 1 kHz schedule
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      accel_count <= '0;
      accel_fresh <= 1'b0;
    end else begin
      accel_count <= accel_tick ? '0 : accel_count + msc_pkg::TICK_W'(1);
      // A sample consumes an update that lands in its own cycle
      if (sample_tick) begin
        accel_fresh <= 1'b0; // RULE_03
      end else if (accel_tick) begin
        accel_fresh <= 1'b1; // RULE_03
      end
    end
  end

  // Frame-sync pin: two-stage synchroniser then change latch
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      fs_meta   <= 1'b0;
      fs_sync   <= 1'b0;
      fs_prev   <= 1'b0;
      fs_latch  <= 1'b0;
      fs_caught <= 1'b0;
    end else begin
      fs_meta <= i_FRAME_SYNC_INPUT;
      fs_sync <= fs_meta;
      fs_prev <= fs_sync;
      if (sample_tick) begin
        fs_latch  <= fs_sync;   // RULE_07
        fs_caught <= 1'b0;
      end else if (fs_change && !fs_caught) begin
        fs_latch  <= fs_sync;   // RULE_06
        fs_caught <= 1'b1;
      end
    end
  end

  // Sample strobe bundle
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      o_SMP <= '0;
    end else begin
      o_SMP.sample_tick <= sample_tick;                  // RULE_04
      o_SMP.accel_new   <= sample_tick && (accel_fresh || accel_tick); // RULE_03
      if (sample_tick) begin
        o_SMP.sync_value  <= fs_latch;                   // RULE_07
        o_SMP.sync_onehot <= next_onehot;                // RULE_08
      end
    end
  end

  // Decoded configuration
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      o_CFG <= '0;
    end else begin
      o_CFG.gyro_selftest    <= {gyro_range_selftest[msc_pkg::ST_X_BIT],
                                 gyro_range_selftest[msc_pkg::ST_Y_BIT],
                                 gyro_range_selftest[msc_pkg::ST_Z_BIT]};  // RULE_11 RULE_13
      o_CFG.accel_selftest   <= {accel_range_selftest[msc_pkg::ST_X_BIT],
                                 accel_range_selftest[msc_pkg::ST_Y_BIT],
                                 accel_range_selftest[msc_pkg::ST_Z_BIT]}; // RULE_12 RULE_13
      o_CFG.gyro_range_code  <= gyro_range_selftest[msc_pkg::RANGE_LSB +: 2];  // RULE_16
      o_CFG.accel_range_code <= accel_range_selftest[msc_pkg::RANGE_LSB +: 2]; // RULE_18
      o_CFG.lowpass_setting  <= lowpass_setting;                               // RULE_10
    end
  end

  // Assertions: register bus
  reserved_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_20
    (sync_and_filter_config[7:6] == 2'b00) && (gyro_range_selftest[2:0] == 3'b000)
    && (accel_range_selftest[2:0] == 3'b000))
    else $error("Reserved bits not zero");

  div_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_05
    (i_WRITE && hit_div) |=> (rate_divider_value == $past(i_WDATA)))
    else $error("Divider write lost");

  div_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_05
    !(i_WRITE && hit_div) |=> $stable(rate_divider_value))
    else $error("Divider changed without write");

  sf_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_09
    (i_WRITE && hit_sf) |=> (sync_and_filter_config == {2'b00, $past(i_WDATA[5:0])}))
    else $error("Config write wrong");

  gyro_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_11
    (i_WRITE && hit_gyro) |=> (gyro_range_selftest == {$past(i_WDATA[7:3]), 3'b000}))
    else $error("Gyro config write wrong");

  accel_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_12
    (i_WRITE && hit_accel) |=> (accel_range_selftest == {$past(i_WDATA[7:3]), 3'b000}))
    else $error("Accel config write wrong");

  gyro_resv_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_17
    (i_WRITE && hit_gyro) |=> (gyro_range_selftest[2:0] == 3'b000))
    else $error("Gyro reserved bits kept");

  read_back_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_09
    (i_READ && hit_sf && !i_WRITE) |=> (o_RDATA == sync_and_filter_config))
    else $error("Config readback wrong");

  unmapped_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_20
    (i_READ && !(hit_div || hit_sf || hit_gyro || hit_accel)) |=> (o_RDATA == 8'h00))
    else $error("Unmapped read not zero");

  rdata_idle_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_20
    !i_READ |=> (o_RDATA == 8'h00))
    else $error("Read data outside its cycle");

  reset_zero_a: assert property (@(posedge I_CLOCK) // RULE_19
    !I_RESET_N |=> (rate_divider_value == msc_pkg::RESET_VALUE) && (o_RDATA == 8'h00)
    && (gyro_range_selftest == msc_pkg::RESET_VALUE) && (o_CFG == '0))
    else $error("Reset values wrong");

  // Assertions: sample timing
  tick_spacing_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_01
    (sample_tick && rate_divider_value == 8'h00 && gyro_fast && !i_WRITE)
    |=> !sample_tick [*7])
    else $error("Sample tick too early");

  tick_divided_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_01
    (base_tick && !sample_tick) |=> (div_count == $past(div_count) + 8'h01))
    else $error("Divider count skipped");

  fast_rate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_02
    (lowpass_setting == 3'h7) |-> (base_period == msc_pkg::TICK_W'(msc_pkg::FAST_CYCLES)))
    else $error("Filter off must use fast rate");

  slow_rate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_02
    (lowpass_setting != msc_pkg::FILT_OFF_LO) && (lowpass_setting != msc_pkg::FILT_OFF_HI)
    |-> (base_period == msc_pkg::TICK_W'(msc_pkg::SLOW_CYCLES)))
    else $error("Filter on must use slow rate");

  base_wrap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_02
    base_tick |=> (base_count == msc_pkg::TICK_W'(0)))
    else $error("Base counter did not wrap");

  accel_wrap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_03
    accel_tick |=> (accel_count == msc_pkg::TICK_W'(0)))
    else $error("Accel counter did not wrap");

  accel_fresh_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_03
    (accel_tick && !sample_tick) |=> accel_fresh)
    else $error("Accel update not remembered");

  accel_used_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_03
    sample_tick |=> !accel_fresh)
    else $error("Accel update reported twice");

  accel_new_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_03
    (sample_tick && accel_tick) |=> o_SMP.accel_new)
    else $error("Accel update not reported");

  tick_out_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_04
    sample_tick |=> o_SMP.sample_tick)
    else $error("Sample strobe missing");

  tick_width_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_04
    o_SMP.sample_tick |=> !o_SMP.sample_tick)
    else $error("Sample strobe too long");

  // Assertions: frame sync
  sync_sample_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_07
    sample_tick |=> (fs_latch == $past(fs_sync)) && (o_SMP.sync_value == $past(fs_latch)))
    else $error("Frame sync not sampled");

  sync_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_07
    !sample_tick |=> $stable(o_SMP.sync_value) && $stable(o_SMP.sync_onehot))
    else $error("Sync output changed between samples");

  sync_catch_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_06
    (fs_change && !fs_caught && !sample_tick) |=> fs_caught && (fs_latch == $past(fs_sync)))
    else $error("Short strobe missed");

  latch_lock_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_06
    (fs_caught && !sample_tick) |=> $stable(fs_latch))
    else $error("Caught strobe overwritten");

  sync_place_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_08
    sample_tick |=> (($past(sync_location_select) == 3'h0) ? (o_SMP.sync_onehot == 8'h00) :
    ($onehot(o_SMP.sync_onehot) && o_SMP.sync_onehot[$past(sync_location_select)])))
    else $error("Sync location wrong");

  // Assertions: exported configuration
  gyro_st_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_11
    (i_WRITE && hit_gyro) |=> ##1 (o_CFG.gyro_selftest == $past(i_WDATA[7:5], 2)))
    else $error("Gyro self-test not applied");

  accel_st_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_12
    (i_WRITE && hit_accel) |=> ##1 (o_CFG.accel_selftest == $past(i_WDATA[7:5], 2)))
    else $error("Accel self-test not applied");

  gyro_rng_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_16
    (i_WRITE && hit_gyro) |=> ##1 (o_CFG.gyro_range_code == $past(i_WDATA[4:3], 2)))
    else $error("Gyro range not applied");

  accel_rng_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_18
    (i_WRITE && hit_accel) |=> ##1 (o_CFG.accel_range_code == $past(i_WDATA[4:3], 2)))
    else $error("Accel range not applied");

  cfg_follow_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N) // RULE_10
    (i_WRITE && hit_sf) |=> ##1 (o_CFG.lowpass_setting == $past(i_WDATA[2:0], 2)))
    else $error("Filter setting not applied");

endmodule : msc_top

// *** tb/tb.sv ***
// Testbench: register access, sample timing and frame-sync insertion
`timescale 1ns/100ps
module tb;
  logic              I_CLOCK;
  logic              I_RESET_N;
  logic [7:0]        i_ADDR;
  logic [7:0]        i_WDATA;
  logic              i_WRITE;
  logic              i_READ;
  logic              i_FRAME_SYNC_INPUT;
  logic [7:0]        o_RDATA;
  msc_pkg::msc_cfg_s o_CFG;
  msc_pkg::msc_smp_s o_SMP;
  logic [7:0]        regs [4];
  int                mismatches = 0;
  int                checked = 0;
  int                seed;
  int                cyc = 0;
  int                last;
  localparam logic [7:0] ADR [4] = '{msc_pkg::ADDR_RATE_DIV, msc_pkg::ADDR_SYNC_FILT,
                                     msc_pkg::ADDR_GYRO_CFG, msc_pkg::ADDR_ACCEL_CFG};
  localparam logic [7:0] MSK [4] = '{msc_pkg::MASK_RATE_DIV, msc_pkg::MASK_SYNC_FILT,
                                     msc_pkg::MASK_GYRO_CFG, msc_pkg::MASK_ACCEL_CFG};

  msc_top u_dut (
    .I_CLOCK            (I_CLOCK),
    .I_RESET_N          (I_RESET_N),
    .i_ADDR             (i_ADDR),
    .i_WDATA            (i_WDATA),
    .i_WRITE            (i_WRITE),
    .i_READ             (i_READ),
    .i_FRAME_SYNC_INPUT (i_FRAME_SYNC_INPUT),
    .o_RDATA            (o_RDATA),
    .o_CFG              (o_CFG),
    .o_SMP              (o_SMP)
  );

  initial begin
    I_CLOCK = 1'b0;
    forever #5 I_CLOCK = ~I_CLOCK;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic fail(string m);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask : fail

  task automatic cmp8(logic [7:0] got, logic [7:0] exp, string m);
    checked++;
    if (got !== exp) fail(m);
  endtask : cmp8

  task automatic cmp_cfg(msc_pkg::msc_cfg_s exp);
    checked++;
    if (o_CFG !== exp) fail("decoded configuration");
  endtask : cmp_cfg

  task automatic cmp_n(int got, int exp, string m);
    checked++;
    if (got != exp) fail(m);
  endtask : cmp_n

  // Accel refresh only ever rides on a sample
  always @(posedge I_CLOCK) begin
    cyc <= cyc + 1;
    if (o_SMP.accel_new === 1'b1 && o_SMP.sample_tick !== 1'b1) fail("lone accel update");
  end

  function automatic msc_pkg::msc_cfg_s exp_cfg();
    exp_cfg.gyro_selftest    = regs[2][7:5];
    exp_cfg.accel_selftest   = regs[3][7:5];
    exp_cfg.gyro_range_code  = regs[2][4:3];
    exp_cfg.accel_range_code = regs[3][4:3];
    exp_cfg.lowpass_setting  = regs[1][2:0];
  endfunction : exp_cfg

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge I_CLOCK);
    i_ADDR  <= a;
    i_WDATA <= d;
    i_WRITE <= 1'b1;
    @(posedge I_CLOCK);
    i_WRITE <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge I_CLOCK);
    i_ADDR <= a;
    i_READ <= 1'b1;
    @(posedge I_CLOCK);
    i_READ <= 1'b0;
    #1 cmp8(o_RDATA, exp, "read data");
    @(posedge I_CLOCK);
    #1 cmp8(o_RDATA, 8'h00, "read data held too long");
  endtask : rd

  // One sample period: set location, maybe pulse the pin, await the tick
  task automatic sample(int per, logic [2:0] code, logic [2:0] filt, bit meas);
    int n;
    bit pulse;
    pulse = ~code[0];
    regs[1] = {2'b00, code, filt};
    wr(msc_pkg::ADDR_SYNC_FILT, regs[1]);
    if (pulse) begin
      repeat (2000) @(posedge I_CLOCK);
      i_FRAME_SYNC_INPUT <= 1'b1;
      repeat (3) @(posedge I_CLOCK);
      i_FRAME_SYNC_INPUT <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge I_CLOCK);
      #1;
      n++;
      if (n > 110000) begin
        fail("no sample tick");
        give_verdict();
      end
    end while (o_SMP.sample_tick !== 1'b1);
    if (meas) cmp_n(cyc - last, per, "sample period");
    last = cyc;
    @(posedge I_CLOCK);
    #1 cmp8({7'd0, o_SMP.sample_tick}, 8'h00, "tick width");
    cmp8({7'd0, o_SMP.sync_value}, {7'd0, pulse}, "frame sync value");
    cmp8(o_SMP.sync_onehot, (code == 3'd0) ? 8'h00 : 8'h01 << code, "sync place");
  endtask : sample

  initial begin
    int k;
    logic [7:0] a;
    logic [7:0] d;
    logic [2:0] st_on;
    int resp;
    seed = 8736;
    I_RESET_N = 1'b0;
    i_ADDR = 8'h00;
    i_WDATA = 8'h00;
    i_WRITE = 1'b0;
    i_READ = 1'b0;
    i_FRAME_SYNC_INPUT = 1'b0;
    repeat (10) @(posedge I_CLOCK);
    I_RESET_N <= 1'b1;
    for (int i = 0; i < 4; i++) regs[i] = 8'h00;
    for (int i = 0; i < 4; i++) rd(ADR[i], 8'h00);
    cmp_cfg(exp_cfg());
    // Random writes, reserved bits, unmapped places and corners
    for (int it = 0; it < 40; it++) begin
      k = {$random(seed)} % 5;
      d = (it < 4) ? 8'hFF : 8'($random(seed));
      a = (k == 4) ? 8'h1D + 8'({$random(seed)} % 64) : ADR[k];
      wr(a, d);
      if (k < 4) regs[k] = d & MSK[k];
      @(posedge I_CLOCK);
      #1 cmp_cfg(exp_cfg());
      rd(a, (k == 4) ? 8'h00 : regs[k]);
    end
    // Host self-test arithmetic on the exported axis enables
    wr(msc_pkg::ADDR_GYRO_CFG, 8'hE0);
    regs[2] = 8'hE0;
    repeat (2) @(posedge I_CLOCK);
    #1 cmp_cfg(exp_cfg());
    st_on = o_CFG.gyro_selftest;
    wr(msc_pkg::ADDR_GYRO_CFG, 8'h00);
    regs[2] = 8'h00;
    repeat (2) @(posedge I_CLOCK);
    #1 cmp_cfg(exp_cfg());
    resp = int'(st_on) - int'(o_CFG.gyro_selftest);
    cmp_n(resp, 7, "self-test response");
    cmp_n(int'(resp > 0 && resp <= 7), 1, "self-test limits");
    // Filter off: 8 kHz base, divider 0; first sample aligns, no pin pulse
    wr(msc_pkg::ADDR_RATE_DIV, 8'h00);
    regs[0] = 8'h00;
    sample(msc_pkg::FAST_CYCLES, 3'd1, 3'd0, 1'b0);
    for (int c = 0; c < 7; c++) begin
      if (c != 1) sample(msc_pkg::FAST_CYCLES, 3'(c), 3'd0, 1'b1);
    end
    // Reserved filter code, divider 1, written right after a tick
    wr(msc_pkg::ADDR_RATE_DIV, 8'h01);
    regs[0] = 8'h01;
    sample(2 * msc_pkg::FAST_CYCLES, 3'd7, 3'd7, 1'b1);
    rd(msc_pkg::ADDR_SYNC_FILT, regs[1]);
    give_verdict();
  end
endmodule : tb
